// *** common/pmpm_pkg.sv ***
/*
 * Package of the multiphase PWM phase manager: register offsets, reset values,
 * timing counts, the strap address table and the state record of the core.
 * Assumes a 20 MHz system clock and an AHB-Lite master with 32-bit data.
 */
// Function
// [RL1] apply one of eight stored configurations chosen by the configuration strap
// [RL2] two outputs share four phases, any mix per output
// [RL3] fixed-period modulator with independently placed leading and trailing edges
// [RL4] pulses of different phases may overlap
// [RL5] insert or remove pulses on regulation error, bounding average pulse rate
// [RL6] switching period stays constant under steady load
// [RL7] bus address comes from the sixteen-entry strap table
// [RL8] automatic phase drop is optional and driven by load current only
// [RL9] second output drops its lowest-numbered assigned phase first
// [RL10] first output drops its highest-numbered assigned phase first
// [RL11] one phase dropped per event, each after the programmed delay
// [RL12] regulation error above fast-add threshold readies all dropped phases
// [RL13] add and drop current thresholds are programmable
// [RL14] dropped phases get periodic low-side pulses to recharge bootstrap
// [RL15] command, margin high and margin low are writable while regulating
// [RL16] host keeps fault limits outside the commanded and margin voltages
// [RL17] every voltage target is clamped between minimum and maximum
// [RL18] an AVS target voltage may replace the commanded target
// [RL19] switching frequency programmable from 200 kHz to 1 MHz
// [RL20] host assigns second output downward from phase 3, first upward
// [RL21] drop delay restarts on every add or fast-add event
package pmpm_pkg;

	// ==================================================================
	// timing
	localparam int CLK_KHZ = 20000;
	localparam int FSW_MIN_KHZ = 200;
	localparam int FSW_MAX_KHZ = 1000;
	localparam int DROP_DLY_US = 1000;
	localparam int REFRESH_PER_US = 500;
	localparam int REFRESH_NS = 500;
	localparam logic [6:0] PER_MIN = 7'(CLK_KHZ / FSW_MAX_KHZ);
	localparam logic [6:0] PER_MAX = 7'(CLK_KHZ / FSW_MIN_KHZ);
	localparam logic [7:0] REFRESH_CYC = 8'((REFRESH_NS * CLK_KHZ + 999999) / 1000000);

	// ==================================================================
	// register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PHMAP = 8'h04;
	localparam logic [7:0] OFF_PERIOD = 8'h08;
	localparam logic [7:0] OFF_DROPDLY = 8'h0c;
	localparam logic [7:0] OFF_REFPER = 8'h10;
	localparam logic [7:0] OFF_THR0 = 8'h14;
	localparam logic [7:0] OFF_THR1 = 8'h18;
	localparam logic [7:0] OFF_FASTTHR = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [3:0] REGION_EDGE = 4'h3;
	localparam logic [1:0] REGION_VOUT = 2'h1;
	localparam logic [2:0] REGION_CFG = 3'h4;
	localparam logic [2:0] VSUB_CMD = 3'h0;
	localparam logic [2:0] VSUB_MHI = 3'h1;
	localparam logic [2:0] VSUB_MLO = 3'h2;
	localparam logic [2:0] VSUB_MIN = 3'h3;
	localparam logic [2:0] VSUB_MAX = 3'h4;
	localparam logic [2:0] VSUB_TGT = 3'h5;

	// ==================================================================
	// control fields and reset values
	localparam int CTRL_RUN = 0;
	localparam int CTRL_AUTODROP = 1;
	localparam int CTRL_MSEL0 = 2;
	localparam logic [1:0] MSEL_HI = 2'h1;
	localparam logic [1:0] MSEL_LO = 2'h2;
	localparam logic [5:0] CTRL_RST = 6'h03;
	localparam logic [6:0] PER_RST = 7'h32;
	localparam logic [7:0] PHMAP_RST = 8'h0f;
	localparam logic [15:0] CFG_RST = {1'b0, PER_RST, PHMAP_RST};
	localparam logic [14:0] EDGE_RST = 15'h1900;
	localparam logic [15:0] THR_RST = 16'h6020;
	localparam logic [7:0] FASTTHR_RST = 8'h40;
	localparam logic [15:0] DROPDLY_RST = 16'(DROP_DLY_US * CLK_KHZ / 1000);
	localparam logic [15:0] REFPER_RST = 16'(REFRESH_PER_US * CLK_KHZ / 1000);
	localparam logic [15:0] VMAX_RST = 16'hffff;

	// strap code to 7-bit bus address, code 0 in the low bits
	localparam logic [111:0] ADDR_TABLE = {
		7'h5f, 7'h5e, 7'h5b, 7'h5a, 7'h57, 7'h56, 7'h53, 7'h52,
		7'h47, 7'h46, 7'h43, 7'h42, 7'h67, 7'h66, 7'h63, 7'h60};

	typedef enum logic {ST_LOAD, ST_RUN} pmpmStage_t;

	typedef struct packed {
		pmpmStage_t        stage;
		logic [5:0]        ctrl;
		logic [7:0][15:0]  cfg;
		logic [2:0]        cfgSel;
		logic [6:0]        busAddr;
		logic [7:0]        phMap;
		logic [6:0]        period;
		logic [6:0]        cnt;
		logic [3:0][14:0]  edges;
		logic [3:0]        act;
		logic [3:0]        pwm;
		logic [3:0]        refr;
		logic [3:0]        insUsed;
		logic [1:0][15:0]  dly;
		logic [15:0]       dropDly;
		logic [15:0]       refPer;
		logic [15:0]       refCnt;
		logic [7:0]        refOn;
		logic [1:0][15:0]  thr;
		logic [7:0]        fastThr;
		logic [1:0][15:0]  vcmd;
		logic [1:0][15:0]  vmhi;
		logic [1:0][15:0]  vmlo;
		logic [1:0][15:0]  vmin;
		logic [1:0][15:0]  vmax;
		logic [1:0][15:0]  avsV;
		logic [1:0]        avsMode;
		logic [1:0][15:0]  target;
		logic              ready;
		logic              wrPend;
		logic [7:0]        wrAddr;
		logic [31:0]       rdata;
	} pmpmState_t;

endpackage

// *** rtl/pmpm_phase_manager.sv ***
/*
 * Multiphase PWM core: dual-edge modulator for four phases, phase-to-output
 * map, automatic drop and add, boot refresh, strap address and configuration
 * choice, clamped voltage targets, AHB-Lite register slave.
 * Assumes current and error inputs synchronous to clock; single word accesses.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module pmpm_phase_manager
	import pmpm_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rstn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [3:0]         addressStrapPin,
	input  wire logic [2:0]         configStrap,
	input  wire logic [7:0]         loadCurrent0,
	input  wire logic [7:0]         loadCurrent1,
	input  wire logic signed [7:0]  regError0,
	input  wire logic signed [7:0]  regError1,
	input  wire logic               avsValid,
	input  wire logic               avsRail,
	input  wire logic [15:0]        avsVoltage,
	output logic [3:0]              pwmOut,
	output logic [3:0]              refreshOut,
	output logic [6:0]              busAddress,
	output logic [15:0]             voutTarget0,
	output logic [15:0]             voutTarget1
);

	// ==================================================================
	// helpers
	function automatic logic [6:0] addrMap(input logic [3:0] code);
		return ADDR_TABLE[7 * code +: 7];
	endfunction

	function automatic logic [6:0] clampPer(input logic [6:0] p);
		return (p < PER_MIN) ? PER_MIN : ((p > PER_MAX) ? PER_MAX : p);
	endfunction

	function automatic logic [3:0] pickLow(input logic [3:0] m);
		return m & (~m + 4'h1);
	endfunction

	function automatic logic [3:0] pickHigh(input logic [3:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (m[i]) r = 4'(1 << i);
		end
		return r;
	endfunction

	// phase-shifted count, a quarter period apart per phase
	function automatic logic [6:0] phCnt(input logic [6:0] c, input logic [6:0] per,
		input logic [1:0] idx);
		logic [7:0] s;
		s = {1'b0, c} + {3'b0, per[6:2]} * {6'b0, idx};
		return (s >= {1'b0, per}) ? 7'(s - {1'b0, per}) : s[6:0];
	endfunction

	function automatic logic [7:0] magOf(input logic signed [7:0] e);
		return e[7] ? 8'(-e) : 8'(e);
	endfunction

	function automatic logic [31:0] regRead(input pmpmState_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			OFF_CTRL:    r = 32'(s.ctrl);
			OFF_PHMAP:   r = 32'(s.phMap);
			OFF_PERIOD:  r = 32'(s.period);
			OFF_DROPDLY: r = 32'(s.dropDly);
			OFF_REFPER:  r = 32'(s.refPer);
			OFF_THR0:    r = 32'(s.thr[0]);
			OFF_THR1:    r = 32'(s.thr[1]);
			OFF_FASTTHR: r = 32'(s.fastThr);
			OFF_STATUS:  r = {13'h0, s.cfgSel, 1'b0, s.busAddr, s.pwm, s.act};
			default: begin
				if (a[7:4] == REGION_EDGE) r = 32'(s.edges[a[3:2]]);
				else if (a[7:6] == REGION_VOUT) begin
					case (a[4:2])
						VSUB_CMD: r = 32'(s.vcmd[a[5]]);
						VSUB_MHI: r = 32'(s.vmhi[a[5]]);
						VSUB_MLO: r = 32'(s.vmlo[a[5]]);
						VSUB_MIN: r = 32'(s.vmin[a[5]]);
						VSUB_MAX: r = 32'(s.vmax[a[5]]);
						VSUB_TGT: r = {15'h0, s.avsMode[a[5]], s.target[a[5]]};
						default:  r = 32'h0;
					endcase
				end else if (a[7:5] == REGION_CFG) r = 32'(s.cfg[a[4:2]]);
			end
		endcase
		return r;
	endfunction

	// ==================================================================
	// state
	pmpmState_t q;
	pmpmState_t n;
	logic [3:0]  am;
	logic [3:0]  a;
	logic [3:0]  pk;
	logic [7:0]  mag;
	logic [7:0]  load;
	logic [7:0]  insThr;
	logic [6:0]  pc;
	logic        errPos;
	logic        errBig;
	logic [15:0] raw;

	// next-state logic
	always_comb begin
		n = q;
		am = 4'h0;
		a = 4'h0;
		pk = 4'h0;
		mag = 8'h0;
		load = 8'h0;
		pc = 7'h0;
		errPos = 1'b0;
		errBig = 1'b0;
		raw = 16'h0;
		insThr = {1'b0, q.fastThr[7:1]};
		n.ready = 1'b1;

		// write data phase
		if (q.wrPend) begin
			case (q.wrAddr)
				OFF_CTRL:  n.ctrl = hwdata[5:0];
				OFF_PHMAP: n.phMap = hwdata[7:0];
				OFF_PERIOD: begin
					n.period = clampPer(hwdata[6:0]); // RL19
					n.cnt = 7'h0;
				end
				OFF_DROPDLY: n.dropDly = hwdata[15:0];
				OFF_REFPER:  n.refPer = hwdata[15:0];
				OFF_THR0:    n.thr[0] = hwdata[15:0]; // RL13
				OFF_THR1:    n.thr[1] = hwdata[15:0]; // RL13
				OFF_FASTTHR: n.fastThr = hwdata[7:0];
				default: begin
					if (q.wrAddr[7:4] == REGION_EDGE) n.edges[q.wrAddr[3:2]] = hwdata[14:0];
					else if (q.wrAddr[7:6] == REGION_VOUT) begin
						case (q.wrAddr[4:2])
							VSUB_CMD: begin
								n.vcmd[q.wrAddr[5]] = hwdata[15:0]; // RL15
								n.avsMode[q.wrAddr[5]] = 1'b0;
							end
							VSUB_MHI: n.vmhi[q.wrAddr[5]] = hwdata[15:0]; // RL15
							VSUB_MLO: n.vmlo[q.wrAddr[5]] = hwdata[15:0]; // RL15
							VSUB_MIN: n.vmin[q.wrAddr[5]] = hwdata[15:0];
							VSUB_MAX: n.vmax[q.wrAddr[5]] = hwdata[15:0];
							default:  n.vmin[q.wrAddr[5]] = q.vmin[q.wrAddr[5]];
						endcase
					end else if (q.wrAddr[7:5] == REGION_CFG)
						n.cfg[q.wrAddr[4:2]] = hwdata[15:0];
				end
			endcase
		end
		n.wrPend = hsel && hready && htrans[1] && hwrite;
		n.wrAddr = haddr[7:0];

		// fast target path, wins over a same-cycle command write
		if (avsValid) begin
			n.avsV[avsRail] = avsVoltage; // RL18
			n.avsMode[avsRail] = 1'b1; // RL18
		end

		case (q.stage)
			ST_LOAD: begin
				// straps caught once, after reset release
				n.cfgSel = configStrap;
				n.busAddr = addrMap(addressStrapPin); // RL7
				n.phMap = q.cfg[configStrap][7:0]; // RL1
				n.period = clampPer(q.cfg[configStrap][14:8]); // RL1
				n.cnt = 7'h0;
				// every assigned phase starts active; load current then trims the count
				n.act = q.cfg[configStrap][3:0]; // RL2
				n.stage = ST_RUN;
			end
			ST_RUN: begin
				// carrier count, fixed period
				if (q.wrPend && q.wrAddr == OFF_PERIOD) n.cnt = 7'h0;
				else if (q.cnt >= q.period - 7'h1) n.cnt = 7'h0; // RL6
				else n.cnt = q.cnt + 7'h1;

				// phase add and drop per output
				n.act = q.act & q.phMap[3:0]; // RL2
				for (int o = 0; o < 2; o++) begin
					am = q.phMap[3:0] & (o == 1 ? q.phMap[7:4] : ~q.phMap[7:4]); // RL2
					a = n.act & am;
					mag = magOf(o == 1 ? regError1 : regError0);
					load = (o == 1) ? loadCurrent1 : loadCurrent0;
					if (mag > q.fastThr || !q.ctrl[CTRL_AUTODROP]) begin
						n.act = n.act | am; // RL12 RL8
						n.dly[o] = 16'h0; // RL21
					end else if (load > q.thr[o][15:8] && (am & ~a) != 4'h0) begin
						pk = (o == 1) ? pickHigh(am & ~a) : pickLow(am & ~a);
						n.act = n.act | pk; // RL8
						n.dly[o] = 16'h0; // RL21
					end else if (load < q.thr[o][7:0] && (a & (a - 4'h1)) != 4'h0) begin
						if (q.dly[o] >= q.dropDly) begin
							pk = (o == 1) ? pickLow(a) : pickHigh(a); // RL9 RL10
							n.act = n.act & ~pk; // RL11
							n.dly[o] = 16'h0;
						end else n.dly[o] = q.dly[o] + 16'h1; // RL11
					end else n.dly[o] = 16'h0;
				end
				if (!q.ctrl[CTRL_RUN]) n.act = 4'h0;
			end
			default: n.stage = ST_LOAD;
		endcase

		// dual-edge modulator, each phase on its own edges
		for (int i = 0; i < 4; i++) begin
			pc = phCnt(q.cnt, q.period, 2'(i));
			mag = magOf(q.phMap[4 + i] ? regError1 : regError0);
			errPos = !(q.phMap[4 + i] ? regError1[7] : regError0[7]);
			errBig = mag > insThr;
			// an inserted pulse ends at the period boundary
			if (pc == 7'h0) begin
				n.insUsed[i] = 1'b0; // RL5
				if (q.insUsed[i]) n.pwm[i] = 1'b0; // RL5
			end
			if (pc == q.edges[i][14:8]) n.pwm[i] = 1'b0; // RL3
			if (pc == q.edges[i][6:0]) n.pwm[i] = !(errBig && !errPos); // RL3 RL5
			// one extra pulse per period at most bounds the average rate
			if (errBig && errPos && !q.insUsed[i] && !q.pwm[i] && pc > q.edges[i][14:8]) begin
				n.pwm[i] = 1'b1; // RL5 RL4
				n.insUsed[i] = 1'b1;
			end
			if (!n.act[i]) n.pwm[i] = 1'b0;
		end

		// boot refresh of dropped phases
		if (q.refCnt >= q.refPer) begin
			n.refCnt = 16'h0;
			n.refOn = REFRESH_CYC; // RL14
		end else begin
			n.refCnt = q.refCnt + 16'h1;
			if (q.refOn != 8'h0) n.refOn = q.refOn - 8'h1;
		end
		n.refr = (n.refOn != 8'h0 && n.stage == ST_RUN && n.ctrl[CTRL_RUN]) ?
			(n.phMap[3:0] & ~n.act) : 4'h0; // RL14

		// voltage targets
		for (int o = 0; o < 2; o++) begin
			case (q.ctrl[CTRL_MSEL0 + 2 * o +: 2])
				MSEL_HI: raw = q.vmhi[o];
				MSEL_LO: raw = q.vmlo[o];
				default: raw = q.vcmd[o];
			endcase
			if (q.avsMode[o]) raw = q.avsV[o]; // RL18
			if (raw > q.vmax[o]) n.target[o] = q.vmax[o]; // RL17
			else if (raw < q.vmin[o]) n.target[o] = q.vmin[o]; // RL17
			else n.target[o] = raw;
		end

		// read data for the next data phase, reflecting this cycle's write
		if (hsel && hready && htrans[1] && !hwrite) n.rdata = regRead(n, haddr[7:0]);
	end

	// state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.cfg <= {8{CFG_RST}};
			q.phMap <= PHMAP_RST;
			q.period <= PER_RST;
			q.edges <= {4{EDGE_RST}};
			q.dropDly <= DROPDLY_RST;
			q.refPer <= REFPER_RST;
			q.thr <= {2{THR_RST}};
			q.fastThr <= FASTTHR_RST;
			q.vmax <= {2{VMAX_RST}};
		end else begin
			q <= n;
		end
	end

	// outputs
	assign hrdata = q.rdata;
	assign hreadyout = q.ready;
	assign hresp = 1'b0;
	assign pwmOut = q.pwm;
	assign refreshOut = q.refr;
	assign busAddress = q.busAddr;
	assign voutTarget0 = q.target[0];
	assign voutTarget1 = q.target[1];

	// ==================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	logic [3:0] am0;
	logic [3:0] am1;
	assign am0 = q.phMap[3:0] & ~q.phMap[7:4];
	assign am1 = q.phMap[3:0] & q.phMap[7:4];

	sequence seqLoaded;
		q.stage == ST_LOAD ##1 q.stage == ST_RUN;
	endsequence

	sequence seqSteady;
		q.stage == ST_RUN && q.ctrl[CTRL_RUN] && $stable(q.phMap);
	endsequence

	property pDrop(logic [3:0] m, logic useHigh);
		seqSteady ##1 (($past(q.act) & ~q.act & m) != 4'h0) |->
			(($past(q.act) & ~q.act & m) ==
			(useHigh ? pickHigh($past(q.act) & m) : pickLow($past(q.act) & m)));
	endproperty

	chk_cfg_applied: assert property (seqLoaded |-> q.cfgSel == $past(configStrap) && q.phMap == q.cfg[q.cfgSel][7:0]) // RL1
		else $error("stored configuration not applied");
	chk_strap_addr: assert property (seqLoaded |-> q.busAddr == addrMap($past(addressStrapPin))) // RL7
		else $error("bus address does not match strap");
	chk_drop_high0: assert property (pDrop(am0, 1'b1)) // RL10
		else $error("first output dropped wrong phase");
	chk_drop_low1: assert property (pDrop(am1, 1'b0)) // RL9
		else $error("second output dropped wrong phase");
	chk_drop_delay: assert property (seqSteady ##1 (($past(q.act) & ~q.act & am0) != 4'h0) |-> $past(q.dly[0]) >= $past(q.dropDly)) // RL11
		else $error("phase dropped before delay");
	chk_add_restart: assert property (seqSteady ##1 ((q.act & ~$past(q.act) & am0) != 4'h0) |-> q.dly[0] == 16'h0) // RL21
		else $error("drop delay not restarted on add");
	chk_fast_add: assert property ((seqSteady and magOf(regError0) > q.fastThr) |=> (q.act & $past(am0)) == $past(am0)) // RL12
		else $error("fast add left a phase dropped");
	chk_period_range: assert property (q.stage == ST_RUN |-> q.period >= PER_MIN && q.period <= PER_MAX) // RL19
		else $error("period outside frequency range");
	chk_count_wrap: assert property (q.stage == ST_RUN && q.cnt == q.period - 7'h1 |=> q.cnt == 7'h0) // RL6
		else $error("carrier count did not wrap");
	chk_target_clamp: assert property (q.vmin[0] <= q.vmax[0] |=> q.target[0] >= $past(q.vmin[0]) && q.target[0] <= $past(q.vmax[0])) // RL17
		else $error("voltage target outside limits");
	chk_refresh_dropped: assert property ((q.refr & (q.act | ~q.phMap[3:0])) == 4'h0 && (q.pwm & ~q.act) == 4'h0) // RL14
		else $error("refresh or pulse on wrong phase");
	chk_avs_take: assert property (avsValid && !avsRail |=> q.avsMode[0] && q.avsV[0] == $past(avsVoltage)) // RL18
		else $error("avs target not taken");

endmodule // pmpm_phase_manager

// *** bench/pmpm_power_stage.sv ***
/*
 * power stage model: four half bridges driven by the pwm and refresh lines.
 * assumes active-high drive commands synchronous to clock.
 */
`timescale 1ns/1ps
module pmpm_power_stage (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [3:0] pwmOut,
	input  wire logic [3:0] refreshOut,
	output logic [3:0]      swNode,
	output logic            conflict
);
	// switch node high only while high side is on and low side is off
	assign swNode = pwmOut & ~refreshOut;
	// sticky flag: both switches of one leg commanded at once would short the rail
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			conflict <= 1'b0;
		else if (|(pwmOut & refreshOut))
			conflict <= 1'b1;
	end
endmodule // pmpm_power_stage

// *** bench/pmpm_phase_manager_bench.sv ***
/*
 * self-checking bench of the phase manager: straps, registers, modulator,
 * phase drop and add, boot refresh, clamped targets.
 * assumes a single zero-wait AHB-Lite slave and a 20 MHz clock.
 */
`timescale 1ns/1ps
module pmpm_phase_manager_bench
	import pmpm_pkg::*;
();
	logic              clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic              avsValid, avsRail, conflict;
	logic [31:0]       haddr, hwdata, hrdata;
	logic [1:0]        htrans;
	logic [2:0]        hsize, configStrap;
	logic [3:0]        addressStrapPin, pwmOut, refreshOut, swNode;
	logic [7:0]        loadCurrent0, loadCurrent1;
	logic signed [7:0] regError0, regError1;
	logic [15:0]       avsVoltage, voutTarget0, voutTarget1;
	logic [6:0]        busAddress;
	int                n_mismatch, checks, cyc;
	logic [6:0]        addrTab [16] = '{7'h60, 7'h63, 7'h66, 7'h67, 7'h42, 7'h43, 7'h46,
		7'h47, 7'h52, 7'h53, 7'h56, 7'h57, 7'h5a, 7'h5b, 7'h5e, 7'h5f};

	assign hready = hreadyout;
	pmpm_phase_manager u_dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .addressStrapPin, .configStrap, .loadCurrent0,
		.loadCurrent1, .regError0, .regError1, .avsValid, .avsRail, .avsVoltage, .pwmOut,
		.refreshOut, .busAddress, .voutTarget0, .voutTarget1);
	pmpm_power_stage u_stage (.clock, .rstn, .pwmOut, .refreshOut, .swNode, .conflict);

	// ==================================================================
	// clock and cycle count
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	// ==================================================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic waitRdy;
		do @(posedge clock);
		while (hready !== 1'b1);
	endtask
	// one single-word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		rd(a, r);
		chk(r, e);
	endtask
	task automatic rst(input logic [3:0] code);
		addressStrapPin <= code;
		configStrap <= code[2:0];
		rstn <= 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
	endtask
	// poll the active-phase field until it changes
	task automatic nextAct(output logic [3:0] v, output int g);
		logic [31:0] r;
		int t0, n;
		t0 = cyc;
		n = 0;
		rd(OFF_STATUS, r);
		v = r[3:0];
		while (r[3:0] === v && n < 60) begin
			rd(OFF_STATUS, r);
			n++;
		end
		v = r[3:0];
		g = cyc - t0;
	endtask
	// watch phase 0 for 60 clocks: rises, period, width, overlap with phase 1
	task automatic measure(output int nr, output int per, output int wid, output logic ov);
		int i, r0;
		logic prv, cur;
		nr = 0;
		per = -1;
		wid = -1;
		r0 = 0;
		ov = 1'b0;
		prv = pwmOut[0];
		for (i = 0; i < 60; i++) begin
			@(posedge clock);
			cur = pwmOut[0];
			if (pwmOut[1:0] === 2'b11) ov = 1'b1;
			if (cur === 1'b1 && prv === 1'b0) begin
				if (nr == 1) per = i - r0;
				if (nr == 0) r0 = i;
				nr++;
			end
			if (cur === 1'b0 && prv === 1'b1 && nr == 1) wid = i - r0;
			prv = cur;
		end
	endtask
	task automatic tgt(input logic o, input logic [15:0] e);
		repeat (2) @(posedge clock);
		chk({16'h0, o ? voutTarget1 : voutTarget0}, {16'h0, e});
	endtask
	task automatic avs(input logic rail, input logic [15:0] v);
		avsRail <= rail;
		avsVoltage <= v;
		avsValid <= 1'b1;
		@(posedge clock);
		avsValid <= 1'b0;
	endtask

	// ==================================================================
	// scenarios
	task automatic testStrap;
		int i;
		logic [31:0] r;
		for (i = 0; i < 16; i++) begin
			rst(4'(i));
			chk({25'h0, busAddress}, {25'h0, addrTab[i]});
			rd(OFF_STATUS, r);
			chk({29'h0, r[18:16]}, 32'(i % 8));
		end
		$display("test strap done");
	endtask
	task automatic testRegs;
		logic [31:0] r;
		rdChk(OFF_CTRL, 32'h3);
		rdChk(OFF_THR0, 32'h6020);
		rdChk(8'h2c, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		wr(OFF_THR1, 32'h5544);
		rdChk(OFF_THR1, 32'h5544);
		wr(OFF_PERIOD, 32'h5);
		rdChk(OFF_PERIOD, 32'h14);
		wr(OFF_PERIOD, 32'h7f);
		rdChk(OFF_PERIOD, 32'h64);
		$display("test regs done");
	endtask
	task automatic testPwm;
		int i, nr, per, wid;
		logic ov;
		wr(OFF_PERIOD, 32'h14);
		for (i = 0; i < 4; i++) wr(8'(8'h30 + 4 * i), 32'h0802);
		measure(nr, per, wid, ov);
		chk(per, 20);
		chk(wid, 6);
		chk({31'h0, ov}, 32'h1);
		regError0 <= 8'sh30;
		measure(nr, per, wid, ov);
		chk({31'h0, nr > 3 && nr <= 6}, 32'h1);
		regError0 <= -8'sh30;
		measure(nr, per, wid, ov);
		chk(nr, 0);
		regError0 <= 8'sh0;
		$display("test pwm done");
	endtask
	task automatic testDrop;
		logic [3:0] v, acc;
		logic [3:0] seq [3] = '{4'h7, 4'h3, 4'h1};
		logic [31:0] r;
		int i, g;
		rst(4'h0);
		wr(OFF_DROPDLY, 32'd10);
		wr(OFF_REFPER, 32'd10);
		wr(OFF_THR0, 32'h6050);
		for (i = 0; i < 3; i++) begin
			nextAct(v, g);
			chk({28'h0, v}, {28'h0, seq[i]});
			chk({31'h0, g >= 8}, 32'h1);
		end
		acc = 4'h0;
		repeat (40) begin
			@(posedge clock);
			acc = acc | refreshOut;
		end
		chk({28'h0, acc}, 32'he);
		regError0 <= 8'sh50;
		repeat (2) @(posedge clock);
		regError0 <= 8'sh0;
		repeat (3) begin
			rd(OFF_STATUS, r);
			chk({28'h0, r[3:0]}, 32'hf);
		end
		nextAct(v, g);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_STATUS, r);
		chk({28'h0, r[3:0]}, 32'hf);
		wr(OFF_CTRL, 32'h0);
		rd(OFF_STATUS, r);
		chk({24'h0, r[7:0]}, 32'h0);
		wr(OFF_CTRL, 32'h3);
		chk({31'h0, conflict}, 32'h0);
		$display("test drop done");
	endtask
	task automatic testOut1;
		logic [3:0] v;
		int g;
		rst(4'h0);
		wr(OFF_DROPDLY, 32'd10);
		wr(OFF_PHMAP, 32'hcf);
		wr(OFF_THR1, 32'h6050);
		nextAct(v, g);
		chk({28'h0, v}, 32'hb);
		$display("test out1 done");
	endtask
	task automatic testVout;
		wr(8'h4c, 32'h100);
		wr(8'h50, 32'h200);
		wr(8'h40, 32'h300);
		tgt(1'b0, 16'h200);
		wr(8'h40, 32'h050);
		tgt(1'b0, 16'h100);
		wr(8'h40, 32'h180);
		tgt(1'b0, 16'h180);
		wr(8'h44, 32'h1c0);
		wr(OFF_CTRL, 32'h7);
		tgt(1'b0, 16'h1c0);
		wr(8'h48, 32'h0a0);
		wr(OFF_CTRL, 32'hb);
		tgt(1'b0, 16'h100);
		wr(OFF_CTRL, 32'h3);
		avs(1'b0, 16'h150);
		tgt(1'b0, 16'h150);
		wr(8'h54, 32'h0);
		rdChk(8'h54, 32'h10150);
		avs(1'b1, 16'h1234);
		tgt(1'b1, 16'h1234);
		wr(8'h40, 32'h180);
		tgt(1'b0, 16'h180);
		$display("test vout done");
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==================================================================
	// main sequence and watchdog
	initial begin
		rstn = 1'b0;
		{hsel, hwrite, avsValid, avsRail} = 4'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		{addressStrapPin, configStrap} = 7'h0;
		loadCurrent0 = 8'h40;
		loadCurrent1 = 8'h40;
		regError0 = 8'sh0;
		regError1 = 8'sh0;
		avsVoltage = 16'h0;
		testStrap();
		testRegs();
		testPwm();
		testDrop();
		testOut1();
		testVout();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		final_report();
	end
endmodule // pmpm_phase_manager_bench
